// *** pkg/sflm_defines.svh ***
`ifndef SFLM_DEFINES_SVH
`define SFLM_DEFINES_SVH
// Instruction codes
`define SFLM_CMD_QUAD_ENTER 8'h35
`define SFLM_CMD_QUAD_EXIT 8'hF5
`define SFLM_CMD_RESET_EN 8'h66
`define SFLM_CMD_RESET 8'h99
`define SFLM_CMD_READ3 8'h03
`define SFLM_CMD_READ4 8'h13
`define SFLM_CMD_DTR_READ 8'h0D
`define SFLM_CMD_PROG3 8'h02
`define SFLM_CMD_PROG4 8'h12
`define SFLM_CMD_ERASE_4K 8'h20
`define SFLM_CMD_ERASE_32K 8'h52
`define SFLM_CMD_ERASE_64K 8'hD8
`define SFLM_CMD_ERASE_CHIP 8'hC7
`define SFLM_CMD_READ_STATUS 8'h05
`define SFLM_CMD_READ_PARAM 8'h61
`define SFLM_CMD_SET_PARAM 8'hC0
`define SFLM_CMD_ADDR4_ENTER 8'hB7
`define SFLM_CMD_ADDR4_EXIT 8'h29
// Bit counts and lane widths
`define SFLM_BITS_BYTE 6'h08
`define SFLM_BITS_ADDR3 6'h18
`define SFLM_BITS_ADDR4 6'h20
`define SFLM_LANE_SINGLE 6'h01
`define SFLM_LANE_QUAD 6'h04
`define SFLM_BEATS_SINGLE 3'h7
`define SFLM_BEATS_QUAD 3'h1
`define SFLM_DTR_DUMMY 4'h6
`define SFLM_PAGE_BYTES 9'h100
`define SFLM_ERASED_BYTE 8'hFF
// Read-parameter byte layout and reset values
`define SFLM_RP_DRIVE_HI 6
`define SFLM_RP_DRIVE_LO 4
`define SFLM_RP_WRAP 2
`define SFLM_RP_BURST_HI 1
`define SFLM_RP_BURST_LO 0
`define SFLM_DRIVE_RESET 3'h0
`define SFLM_DRIVE_LAST 3'h5
`define SFLM_BURST_RESET 2'h0
`define SFLM_WRAP_RESET 1'b0
// Wrap masks for 8/16/32/64 byte bursts
`define SFLM_WRAP_MASK_8 32'h0000_0007
`define SFLM_WRAP_MASK_16 32'h0000_000F
`define SFLM_WRAP_MASK_32 32'h0000_001F
`define SFLM_WRAP_MASK_64 32'h0000_003F
// Status byte layout
`define SFLM_SR_BUSY 0
`define SFLM_SR_ADDR4 1
`define SFLM_SR_QUAD 6
// Pin synchroniser
`define SFLM_SYNC_RESET 7'h7F
`endif

// *** pkg/sflm_pkg.sv ***
package sflm_pkg;
  // Link command phases
  typedef enum {ST_CMD, ST_ADDR, ST_DUMMY, ST_RDATA, ST_WDATA, ST_PARAM, ST_IGNORE} sflm_state_t;
  // Erase sizes
  typedef enum logic [1:0] {ERASE_4K, ERASE_32K, ERASE_64K, ERASE_CHIP} sflm_erase_t;
endpackage

// *** design/sflm_link.sv ***
// The implementer's own choices: the two-stage pin synchroniser and the four-byte read buffer.
`timescale 1ns/1ps
`include "sflm_defines.svh"

module sflm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_clear,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Honest full and empty
  assign o_ready = (count != (AW+1)'(DEPTH)) && !i_clear;
  assign o_valid = (count != '0);
  assign o_data = mem[rd_ptr];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  // Storage
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr_ptr] <= i_data;
  end

  // Pointers and fill level
  always_ff @(posedge i_clk)
  begin
    if (i_reset || i_clear)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sflm_fifo

// Overview of operation
// - Single-line mode: command, address and write data sampled on serial clock rise.
// - Clock modes (0,0) and (1,1) both work; host idles clock accordingly.
// - Single-line mode returns read data and status on serial_out.
// - Instruction 35h switches to four-wire command mode.
// - Instruction F5h in four-wire mode returns to single-line mode.
// - Power-on, hardware or software reset forces single-line mode.
// - Four-wire mode: serial_in, serial_out, protect and pause pins become quad lines 0-3.
// - Four-wire mode: instruction takes two clocks, four bits each.
// - Double-edge read: address sampled and data driven on both clock edges.
// - Read parameters select 8/16/32/64 byte wrap; read address wraps inside.
// - Six drive-strength codes selectable; codes 6 and 7 are ignored, last legal code stays in effect.
// - Erase of 4K sector, 32K block, 64K block or whole array.
// - Program takes 1 to 256 bytes within one page; more are ignored.
// - Three- and four-byte address modes; host sends matching address length.
// - Erased array reads all ones; missing data reads as ones.
module sflm_link (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Link pins
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_hw_reset_n,
  input wire logic [3:0] i_quad_line,
  output logic [3:0] o_quad_line,
  output logic [3:0] o_quad_line_oe,
  // Array read stream
  output logic o_rd_req,
  output logic [31:0] o_rd_addr,
  input wire logic [7:0] i_rd_data,
  // Array program
  output logic o_wr_valid,
  output logic [31:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  // Array erase
  output logic o_erase_valid,
  output logic [1:0] o_erase_kind,
  output logic [31:0] o_erase_addr,
  // Status and settings
  input wire logic i_array_busy,
  output logic o_quad_mode,
  output logic o_addr4_mode,
  output logic [2:0] o_drive_strength
);
  logic [6:0] pin_meta;
  logic [6:0] pin_sync;
  logic sck_d;
  logic cs_d;
  logic cs_high;
  logic rise;
  logic fall;
  logic in_ev;
  logic out_ev;
  sflm_pkg::sflm_state_t st;
  logic [7:0] cmd;
  logic quad;
  logic addr4;
  logic rst_armed;
  logic [2:0] drive;
  logic [1:0] burst;
  logic wrap_en;
  logic dtr;
  logic [31:0] rx_sr;
  logic [31:0] next_rx;
  logic [5:0] rx_cnt;
  logic [5:0] lane;
  logic [5:0] rx_target;
  logic rx_active;
  logic rx_done;
  logic [3:0] dummy_cnt;
  logic [31:0] addr;
  logic rd_pend;
  logic fifo_in_ready;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic fifo_pop;
  logic from_fifo;
  logic [7:0] tx_sr;
  logic [7:0] next_tx;
  logic [2:0] tx_cnt;
  logic [8:0] wr_cnt;
  logic erase_armed;
  logic sw_reset;

  // Address length of a command in the active mode
  function automatic logic [5:0] addr_bits(input logic [7:0] c, input logic a4);
    addr_bits = (a4 || c == `SFLM_CMD_READ4 || c == `SFLM_CMD_PROG4) ?
                `SFLM_BITS_ADDR4 : `SFLM_BITS_ADDR3;
  endfunction

  // Phase that follows an instruction byte
  function automatic sflm_pkg::sflm_state_t after_cmd(input logic [7:0] c);
    unique case (c)
      `SFLM_CMD_READ3, `SFLM_CMD_READ4, `SFLM_CMD_DTR_READ, `SFLM_CMD_PROG3,
      `SFLM_CMD_PROG4, `SFLM_CMD_ERASE_4K, `SFLM_CMD_ERASE_32K,
      `SFLM_CMD_ERASE_64K: after_cmd = sflm_pkg::ST_ADDR;
      `SFLM_CMD_READ_STATUS, `SFLM_CMD_READ_PARAM: after_cmd = sflm_pkg::ST_RDATA;
      `SFLM_CMD_SET_PARAM: after_cmd = sflm_pkg::ST_PARAM;
      default: after_cmd = sflm_pkg::ST_IGNORE;
    endcase
  endfunction

  // Next read address, wrapping inside the burst when enabled
  function automatic logic [31:0] next_addr(input logic [31:0] a, input logic wr,
                                            input logic [1:0] b);
    logic [31:0] m;
    m = `SFLM_WRAP_MASK_8;
    unique case (b)
      2'h0: m = `SFLM_WRAP_MASK_8;
      2'h1: m = `SFLM_WRAP_MASK_16;
      2'h2: m = `SFLM_WRAP_MASK_32;
      2'h3: m = `SFLM_WRAP_MASK_64;
    endcase
    next_addr = wr ? ((a & ~m) | ((a + 32'h0000_0001) & m)) : a + 32'h0000_0001;
  endfunction

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  // Two-stage pin synchroniser
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      pin_meta <= `SFLM_SYNC_RESET;
      pin_sync <= `SFLM_SYNC_RESET;
      sck_d <= 1'b0;
      cs_d <= 1'b1;
    end
    else
    begin
      pin_meta <= {i_hw_reset_n, i_sck, i_cs_n, i_quad_line};
      pin_sync <= pin_meta;
      sck_d <= pin_sync[5];
      cs_d <= pin_sync[4];
    end
  end

  // Edge events; either idle level of the clock is accepted
  assign cs_high = pin_sync[4];
  assign rise = pin_sync[5] && !sck_d && !cs_high;
  assign fall = !pin_sync[5] && sck_d && !cs_high;
  assign dtr = (cmd == `SFLM_CMD_DTR_READ);
  assign in_ev = rise || (fall && dtr && st == sflm_pkg::ST_ADDR);
  assign out_ev = fall || (rise && dtr && st == sflm_pkg::ST_RDATA);

  // Receive shifter: one or four lines per beat
  assign lane = quad ? `SFLM_LANE_QUAD : `SFLM_LANE_SINGLE;
  assign next_rx = quad ? {rx_sr[27:0], pin_sync[3:0]} : {rx_sr[30:0], pin_sync[0]};
  assign rx_active = st inside {sflm_pkg::ST_CMD, sflm_pkg::ST_ADDR, sflm_pkg::ST_WDATA,
                                sflm_pkg::ST_PARAM};
  assign rx_target = (st == sflm_pkg::ST_ADDR) ? addr_bits(cmd, addr4) : `SFLM_BITS_BYTE;
  assign rx_done = in_ev && rx_active && (rx_cnt + lane == rx_target);
  assign sw_reset = rx_done && st == sflm_pkg::ST_CMD && rst_armed &&
                    next_rx[7:0] == `SFLM_CMD_RESET;

  always_ff @(posedge i_clk)
  begin
    if (i_reset || cs_high)
    begin
      rx_sr <= '0;
      rx_cnt <= '0;
    end
    else if (in_ev && rx_active)
    begin
      rx_sr <= next_rx;
      rx_cnt <= rx_done ? '0 : rx_cnt + lane;
    end
  end

  // Command phase sequencer
  always_ff @(posedge i_clk)
  begin
    if (i_reset || cs_high)
    begin
      st <= sflm_pkg::ST_CMD;
      dummy_cnt <= '0;
    end
    else
    begin
      unique case (st)
        sflm_pkg::ST_CMD:
          if (rx_done)
            st <= after_cmd(next_rx[7:0]);
        sflm_pkg::ST_ADDR:
          if (rx_done)
          begin
            if (cmd == `SFLM_CMD_READ3 || cmd == `SFLM_CMD_READ4)
              st <= sflm_pkg::ST_RDATA;
            else if (dtr)
              st <= sflm_pkg::ST_DUMMY;
            else if (cmd == `SFLM_CMD_PROG3 || cmd == `SFLM_CMD_PROG4)
              st <= sflm_pkg::ST_WDATA;
            else
              st <= sflm_pkg::ST_IGNORE;
          end
        sflm_pkg::ST_DUMMY:
          if (rise)
          begin
            dummy_cnt <= dummy_cnt + 4'h1;
            if (dummy_cnt == `SFLM_DTR_DUMMY - 4'h1)
              st <= sflm_pkg::ST_RDATA;
          end
        sflm_pkg::ST_PARAM:
          if (rx_done)
            st <= sflm_pkg::ST_IGNORE;
        sflm_pkg::ST_RDATA, sflm_pkg::ST_WDATA, sflm_pkg::ST_IGNORE: st <= st;
      endcase
    end
  end

  // Instruction latch
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      cmd <= '0;
    else if (rx_done && st == sflm_pkg::ST_CMD)
      cmd <= next_rx[7:0];
  end

  // Link mode and read parameters
  always_ff @(posedge i_clk)
  begin
    if (i_reset || !pin_sync[6] || sw_reset)
    begin
      quad <= 1'b0;
      addr4 <= 1'b0;
      rst_armed <= 1'b0;
      drive <= `SFLM_DRIVE_RESET;
      burst <= `SFLM_BURST_RESET;
      wrap_en <= `SFLM_WRAP_RESET;
    end
    else if (rx_done && st == sflm_pkg::ST_CMD)
    begin
      rst_armed <= (next_rx[7:0] == `SFLM_CMD_RESET_EN);
      if (!quad && next_rx[7:0] == `SFLM_CMD_QUAD_ENTER)
        quad <= 1'b1;
      if (quad && next_rx[7:0] == `SFLM_CMD_QUAD_EXIT)
        quad <= 1'b0;
      if (next_rx[7:0] == `SFLM_CMD_ADDR4_ENTER)
        addr4 <= 1'b1;
      if (next_rx[7:0] == `SFLM_CMD_ADDR4_EXIT)
        addr4 <= 1'b0;
    end
    else if (rx_done && st == sflm_pkg::ST_PARAM)
    begin
      if (next_rx[`SFLM_RP_DRIVE_HI:`SFLM_RP_DRIVE_LO] <= `SFLM_DRIVE_LAST)
        drive <= next_rx[`SFLM_RP_DRIVE_HI:`SFLM_RP_DRIVE_LO];
      burst <= next_rx[`SFLM_RP_BURST_HI:`SFLM_RP_BURST_LO];
      wrap_en <= next_rx[`SFLM_RP_WRAP];
    end
  end

  // Command address, stepped per fetch
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      addr <= '0;
    else if (rx_done && st == sflm_pkg::ST_ADDR)
      addr <= (rx_target == `SFLM_BITS_ADDR4) ? next_rx : {8'h00, next_rx[23:0]};
    else if (o_rd_req)
      addr <= next_addr(addr, wrap_en, burst);
  end

  // Array fetch: one request outstanding, stalled by a full buffer
  assign from_fifo = (cmd != `SFLM_CMD_READ_STATUS) && (cmd != `SFLM_CMD_READ_PARAM);
  assign o_rd_req = st == sflm_pkg::ST_RDATA && from_fifo && fifo_in_ready && !rd_pend &&
                    !cs_high;
  assign o_rd_addr = addr;

  always_ff @(posedge i_clk)
  begin
    if (i_reset || cs_high)
      rd_pend <= 1'b0;
    else
      rd_pend <= o_rd_req;
  end

  sflm_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_clear(cs_high),
    .i_valid(rd_pend),
    .o_ready(fifo_in_ready),
    .i_data(i_rd_data),
    .o_valid(fifo_valid),
    .i_ready(fifo_pop),
    .o_data(fifo_data)
  );

  // Transmit byte selection and shifting
  assign fifo_pop = out_ev && st == sflm_pkg::ST_RDATA && tx_cnt == '0 && from_fifo;

  always_comb
  begin
    next_tx = tx_sr;
    if (out_ev && st == sflm_pkg::ST_RDATA)
    begin
      if (tx_cnt != '0)
        next_tx = quad ? {tx_sr[3:0], 4'h0} : {tx_sr[6:0], 1'b0};
      else if (cmd == `SFLM_CMD_READ_STATUS)
      begin
        next_tx = '0;
        next_tx[`SFLM_SR_BUSY] = i_array_busy;
        next_tx[`SFLM_SR_ADDR4] = addr4;
        next_tx[`SFLM_SR_QUAD] = quad;
      end
      else if (cmd == `SFLM_CMD_READ_PARAM)
      begin
        next_tx = '0;
        next_tx[`SFLM_RP_DRIVE_HI:`SFLM_RP_DRIVE_LO] = drive;
        next_tx[`SFLM_RP_WRAP] = wrap_en;
        next_tx[`SFLM_RP_BURST_HI:`SFLM_RP_BURST_LO] = burst;
      end
      else
        next_tx = fifo_valid ? fifo_data : `SFLM_ERASED_BYTE;
    end
  end

  // Output lane values changed only on output events; lane enables follow the read phase
  always_ff @(posedge i_clk)
  begin
    if (i_reset || cs_high)
    begin
      tx_sr <= `SFLM_ERASED_BYTE;
      tx_cnt <= '0;
      o_quad_line <= '0;
      o_quad_line_oe <= '0;
    end
    else
    begin
      tx_sr <= next_tx;
      if (out_ev && st == sflm_pkg::ST_RDATA)
        tx_cnt <= (tx_cnt != '0) ? tx_cnt - 3'h1 :
                  (quad ? `SFLM_BEATS_QUAD : `SFLM_BEATS_SINGLE);
      if (out_ev)
        o_quad_line <= quad ? next_tx[7:4] : {2'b00, next_tx[7], 1'b0};
      o_quad_line_oe <= (st != sflm_pkg::ST_RDATA) ? 4'h0 : (quad ? 4'hF : 4'h2);
    end
  end

  // Program data, limited to one page
  always_ff @(posedge i_clk)
  begin
    if (i_reset || cs_high)
    begin
      wr_cnt <= '0;
      o_wr_valid <= 1'b0;
      o_wr_addr <= '0;
      o_wr_data <= '0;
    end
    else
    begin
      o_wr_valid <= 1'b0;
      if (rx_done && st == sflm_pkg::ST_WDATA && wr_cnt < `SFLM_PAGE_BYTES)
      begin
        o_wr_valid <= 1'b1;
        o_wr_data <= next_rx[7:0];
        o_wr_addr <= {addr[31:8], addr[7:0] + wr_cnt[7:0]};
        wr_cnt <= wr_cnt + 9'h001;
      end
    end
  end

  // Erase issued when select rises at a byte boundary
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      erase_armed <= 1'b0;
      o_erase_valid <= 1'b0;
      o_erase_kind <= '0;
      o_erase_addr <= '0;
    end
    else
    begin
      o_erase_valid <= 1'b0;
      if (cs_high && !cs_d)
      begin
        o_erase_valid <= erase_armed;
        erase_armed <= 1'b0;
      end
      else if (rx_done && st == sflm_pkg::ST_CMD && next_rx[7:0] == `SFLM_CMD_ERASE_CHIP)
      begin
        erase_armed <= 1'b1;
        o_erase_kind <= sflm_pkg::ERASE_CHIP;
        o_erase_addr <= '0;
      end
      else if (rx_done && st == sflm_pkg::ST_ADDR && cmd inside {`SFLM_CMD_ERASE_4K,
               `SFLM_CMD_ERASE_32K, `SFLM_CMD_ERASE_64K})
      begin
        erase_armed <= 1'b1;
        o_erase_kind <= (cmd == `SFLM_CMD_ERASE_4K) ? sflm_pkg::ERASE_4K :
                        (cmd == `SFLM_CMD_ERASE_32K) ? sflm_pkg::ERASE_32K :
                        sflm_pkg::ERASE_64K;
        o_erase_addr <= (rx_target == `SFLM_BITS_ADDR4) ? next_rx : {8'h00, next_rx[23:0]};
      end
      else if (rise)
        erase_armed <= 1'b0;
    end
  end

  assign o_quad_mode = quad;
  assign o_addr4_mode = addr4;
  assign o_drive_strength = drive;

  // Checks
  sequence s_enter_quad;
    rx_done && st == sflm_pkg::ST_CMD && !quad && next_rx[7:0] == `SFLM_CMD_QUAD_ENTER;
  endsequence
  sequence s_exit_quad;
    rx_done && st == sflm_pkg::ST_CMD && quad && next_rx[7:0] == `SFLM_CMD_QUAD_EXIT;
  endsequence
  property p_quad_enter;
    s_enter_quad |=> quad;
  endproperty
  a_quad_enter: assert property (p_quad_enter) else $error("quad mode not entered");
  property p_quad_exit;
    s_exit_quad |=> !quad;
  endproperty
  a_quad_exit: assert property (p_quad_exit) else $error("quad mode not left");
  property p_hw_reset;
    !pin_sync[6] |=> !quad && !addr4;
  endproperty
  a_hw_reset: assert property (p_hw_reset) else $error("reset left quad mode");
  property p_quad_cmd_two_beats;
    (st == sflm_pkg::ST_CMD && quad && in_ev && rx_cnt == `SFLM_LANE_QUAD) |-> rx_done;
  endproperty
  a_quad_cmd_two_beats: assert property (p_quad_cmd_two_beats) else $error("quad cmd length");
  property p_single_lanes;
    (st == sflm_pkg::ST_RDATA && !quad && !cs_high) |=> o_quad_line_oe == 4'h2;
  endproperty
  a_single_lanes: assert property (p_single_lanes) else $error("single lane enable");
  property p_quad_lanes;
    (st == sflm_pkg::ST_RDATA && quad) ##1 (st == sflm_pkg::ST_RDATA) |-> o_quad_line_oe == 4'hF;
  endproperty
  a_quad_lanes: assert property (p_quad_lanes) else $error("quad lane enable");
  property p_wrap;
    (o_rd_req && wrap_en) |=> (addr & ~`SFLM_WRAP_MASK_64) == $past(addr & ~`SFLM_WRAP_MASK_64);
  endproperty
  a_wrap: assert property (p_wrap) else $error("read address left burst");
  property p_drive_hold;
    !(rx_done && st == sflm_pkg::ST_PARAM) && pin_sync[6] && !sw_reset |=> $stable(drive);
  endproperty
  a_drive_hold: assert property (p_drive_hold) else $error("drive changed");
  property p_drive_legal;
    drive <= `SFLM_DRIVE_LAST;
  endproperty
  a_drive_legal: assert property (p_drive_legal) else $error("illegal drive code");
  property p_page_limit;
    o_wr_valid |-> wr_cnt <= `SFLM_PAGE_BYTES && wr_cnt != 9'h000;
  endproperty
  a_page_limit: assert property (p_page_limit) else $error("page overrun");
  property p_out_on_fall;
    !quad && !dtr && !cs_high && $changed(o_quad_line[1]) |-> $past(fall);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("output off falling edge");
endmodule // sflm_link

// *** sim/sflm_host.sv ***
`timescale 1ns/1ps
module sflm_host (
  // Clock
  input wire logic i_clk,
  // Link pins
  output logic o_sck,
  output logic o_cs_n,
  output logic [3:0] o_line,
  output logic [3:0] o_line_oe,
  input wire logic [3:0] i_line
);
  logic cpol = 1'b0;
  logic quad = 1'b0;

  // Idle pins at time zero
  initial
  begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_line = 4'hF;
    o_line_oe = 4'h0;
  end

  // Wait whole clock cycles
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // Select the device, clock parked at idle level
  task automatic start();
    o_sck <= cpol;
    o_line_oe <= quad ? 4'h0 : 4'hC;
    tick(4);
    o_cs_n <= 1'b0;
    tick(4);
  endtask

  // One byte: launch on fall, sample one cycle after rise
  task automatic xfer(input logic [7:0] tx, input logic drive, output logic [7:0] rx);
    int beats;
    beats = quad ? 2 : 8;
    rx = 8'h00;
    for (int b = 0; b < beats; b++)
    begin
      o_sck <= 1'b0;
      o_line_oe <= !drive ? (quad ? 4'h0 : 4'hC) : (quad ? 4'hF : 4'hD);
      o_line <= quad ? (b == 0 ? tx[7:4] : tx[3:0]) : {3'b111, tx[7 - b]};
      tick(4);
      o_sck <= 1'b1;
      tick(1);
      rx = quad ? {rx[3:0], i_line} : {rx[6:0], i_line[1]};
      tick(3);
    end
  endtask

  // Double-edge byte: one bit per clock edge, first edge a fall
  task automatic xfer_dtr(input logic [7:0] tx, input logic drive, output logic [7:0] rx);
    rx = 8'h00;
    for (int b = 0; b < 8; b++)
    begin
      o_line_oe <= drive ? 4'hD : 4'hC;
      o_line <= {3'b111, tx[7 - b]};
      tick(2);
      o_sck <= ~o_sck;
      tick(4);
      rx = {rx[6:0], i_line[1]};
    end
  endtask

  // Bare clock periods with the lines released, as dummy cycles
  task automatic pulse(input int n);
    o_line_oe <= 4'hC;
    repeat (n)
    begin
      o_sck <= 1'b0;
      tick(4);
      o_sck <= 1'b1;
      tick(4);
    end
  endtask

  // End the frame at a byte boundary, no rise after the last bit
  task automatic stop();
    o_sck <= cpol;
    tick(4);
    o_cs_n <= 1'b1;
    o_line_oe <= 4'h0;
    tick(8);
  endtask
endmodule // sflm_host

// *** sim/tb_sflm_link.sv ***
`timescale 1ns/1ps
module tb_sflm_link;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_hw_reset_n = 1'b1;
  logic i_array_busy = 1'b0;
  logic [7:0] i_rd_data = 8'h00;
  logic float_q = 1'b0;
  logic [3:0] oe_seen;
  logic sck, cs_n, rd_req, wr_valid, er_valid, quad_mode, addr4_mode;
  logic [3:0] dut_out, dut_oe, host_out, host_oe, pin_level;
  logic [31:0] rd_addr, wr_addr, er_addr;
  logic [7:0] wr_data;
  logic [1:0] er_kind;
  logic [2:0] drive;
  logic [7:0] tx_q [$];
  logic [7:0] rx_q [$];
  logic [39:0] wr_q [$];
  logic [33:0] er_q [$];
  int bad_count = 0;
  int total_checks = 0;

  // 40 MHz clock
  always #12.5 i_clk = ~i_clk;

  // Undriven lines toggle so stale values never look valid
  always @(posedge i_clk) float_q <= ~float_q;
  assign pin_level = (dut_oe & dut_out) | (~dut_oe & host_oe & host_out)
    | (~dut_oe & ~host_oe & {4{float_q}});

  // Array model: byte answers the cycle after the request
  always @(posedge i_clk)
  begin
    if (rd_req)
      i_rd_data <= rd_addr[7:0] ^ 8'hA5;
  end

  // Capture program and erase pulses, and the read enables seen
  always @(posedge i_clk)
  begin
    if (wr_valid)
      wr_q.push_back({wr_addr, wr_data});
    if (er_valid)
      er_q.push_back({er_kind, er_addr});
    if (dut_oe != 4'h0)
      oe_seen <= dut_oe;
  end

  sflm_host i_host (
    .i_clk(i_clk), .o_sck(sck), .o_cs_n(cs_n), .o_line(host_out), .o_line_oe(host_oe),
    .i_line(pin_level)
  );

  sflm_link i_dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_sck(sck), .i_cs_n(cs_n),
    .i_hw_reset_n(i_hw_reset_n), .i_quad_line(pin_level), .o_quad_line(dut_out),
    .o_quad_line_oe(dut_oe), .o_rd_req(rd_req), .o_rd_addr(rd_addr), .i_rd_data(i_rd_data),
    .o_wr_valid(wr_valid), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
    .o_erase_valid(er_valid), .o_erase_kind(er_kind), .o_erase_addr(er_addr),
    .i_array_busy(i_array_busy), .o_quad_mode(quad_mode), .o_addr4_mode(addr4_mode),
    .o_drive_strength(drive)
  );

  // Compare one result
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Print counts and verdict, then end
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One framed command: opcode, address bytes, queued write bytes, read bytes
  task automatic cmd(input logic [7:0] op, input logic [31:0] addr, input int na, input int nr);
    logic [7:0] r;
    rx_q = {};
    oe_seen = 4'h0;
    i_host.start();
    i_host.xfer(op, 1'b1, r);
    for (int i = na - 1; i >= 0; i--)
      i_host.xfer(addr[8 * i +: 8], 1'b1, r);
    while (tx_q.size() > 0)
      i_host.xfer(tx_q.pop_front(), 1'b1, r);
    for (int i = 0; i < nr; i++)
    begin
      i_host.xfer(8'hFF, 1'b0, r);
      rx_q.push_back(r);
    end
    i_host.stop();
  endtask

  // Hang guard
  initial
  begin
    repeat (90000) @(posedge i_clk);
    bad_count++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    logic [7:0] ops [4];
    logic [7:0] r;
    int size;
    ops = '{8'h20, 8'h52, 8'hD8, 8'hC7};
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    i_host.tick(6);
    // Plain read, address steps per byte
    cmd(8'h03, 32'h0000_0010, 3, 3);
    for (int i = 0; i < 3; i++)
      chk(40'(rx_q[i]), 40'((8'h10 + i) ^ 8'hA5));
    chk(40'(oe_seen), 40'h2);
    // Status in clock mode 3
    i_host.cpol = 1'b1;
    i_array_busy <= 1'b1;
    cmd(8'h05, 32'h0, 0, 1);
    chk(40'(rx_q[0]), 40'h01);
    i_host.cpol = 1'b0;
    i_array_busy <= 1'b0;
    // Four-wire entry, status over four lines, exit
    cmd(8'h35, 32'h0, 0, 0);
    chk(40'(quad_mode), 40'h1);
    i_host.quad = 1'b1;
    cmd(8'h05, 32'h0, 0, 1);
    chk(40'(rx_q[0]), 40'h40);
    chk(40'(oe_seen), 40'hF);
    cmd(8'hF5, 32'h0, 0, 0);
    i_host.quad = 1'b0;
    chk(40'(quad_mode), 40'h0);
    // Every drive code, then a code out of range is dropped
    for (int d = 0; d < 6; d++)
    begin
      tx_q = '{8'(d << 4)};
      cmd(8'hC0, 32'h0, 0, 0);
      chk(40'(drive), 40'(d));
    end
    tx_q = '{8'h74};
    cmd(8'hC0, 32'h0, 0, 0);
    chk(40'(drive), 40'h5);
    // Every burst length wraps at its boundary
    for (int b = 0; b < 4; b++)
    begin
      size = 8 << b;
      tx_q = '{8'(8'h54 | b)};
      cmd(8'hC0, 32'h0, 0, 0);
      cmd(8'h03, 32'(size - 1), 3, 2);
      chk(40'(rx_q[0]), 40'((size - 1) ^ 8'hA5));
      chk(40'(rx_q[1]), 40'hA5);
    end
    cmd(8'h61, 32'h0, 0, 1);
    chk(40'(rx_q[0]), 40'h57);
    tx_q = '{8'h50};
    cmd(8'hC0, 32'h0, 0, 0);
    // Program across the page end wraps inside the page
    tx_q = '{8'h11, 8'h22};
    cmd(8'h02, 32'h0000_01FF, 3, 0);
    chk(wr_q[0], {32'h0000_01FF, 8'h11});
    chk(wr_q[1], {32'h0000_0100, 8'h22});
    // Each erase size
    for (int k = 0; k < 4; k++)
    begin
      cmd(ops[k], 32'h0000_3000, k == 3 ? 0 : 3, 0);
      chk(40'(er_q.pop_front()), 40'({2'(k), k == 3 ? 32'h0 : 32'h0000_3000}));
    end
    // Four-byte addressing, by mode and by the dedicated commands
    cmd(8'hB7, 32'h0, 0, 0);
    chk(40'(addr4_mode), 40'h1);
    cmd(8'h03, 32'h0000_0020, 4, 1);
    chk(40'(rx_q[0]), 40'h85);
    cmd(8'h29, 32'h0, 0, 0);
    chk(40'(addr4_mode), 40'h0);
    cmd(8'h13, 32'h0000_0030, 4, 1);
    chk(40'(rx_q[0]), 40'h95);
    tx_q = '{8'h33};
    cmd(8'h12, 32'h0000_0208, 4, 0);
    chk(wr_q[2], {32'h0000_0208, 8'h33});
    // Double-edge read: address and data on both clock edges
    i_host.start();
    i_host.xfer(8'h0D, 1'b1, r);
    i_host.xfer_dtr(8'h00, 1'b1, r);
    i_host.xfer_dtr(8'h00, 1'b1, r);
    i_host.xfer_dtr(8'h42, 1'b1, r);
    i_host.pulse(6);
    i_host.xfer_dtr(8'hFF, 1'b0, r);
    chk(40'(r), 40'(8'h42 ^ 8'hA5));
    i_host.xfer_dtr(8'hFF, 1'b0, r);
    chk(40'(r), 40'(8'h43 ^ 8'hA5));
    i_host.stop();
    // Software reset from four-wire mode
    cmd(8'h35, 32'h0, 0, 0);
    i_host.quad = 1'b1;
    cmd(8'h66, 32'h0, 0, 0);
    cmd(8'h99, 32'h0, 0, 0);
    i_host.quad = 1'b0;
    chk(40'(quad_mode), 40'h0);
    // Hardware reset pin clears modes and settings
    tx_q = '{8'h30};
    cmd(8'hC0, 32'h0, 0, 0);
    chk(40'(drive), 40'h3);
    cmd(8'h35, 32'h0, 0, 0);
    i_hw_reset_n <= 1'b0;
    i_host.tick(8);
    i_hw_reset_n <= 1'b1;
    i_host.tick(8);
    chk(40'(quad_mode), 40'h0);
    chk(40'(drive), 40'h0);
    report_and_stop();
  end
endmodule // tb_sflm_link
